// ==== hdl/serial_shifter_link.sv ====
// memory-mapped 16-bit serial shifter with counter, direction bit and link handshake
// assumes a processor that holds sel until ack and a matching shifter on the far end
//
// Contract
// - whole-word loadable 16-bit two-way shift register
// - four-bit counter, direction bit, address decoder
// - link uses one data, two handshake lines
// - control word loads count and direction
// - data store takes direction, starts shifting
// - counter returns to zero, meaning sixteen
// - left and right shift modes by bit
// - control logic runs from supplied clock
// - any data read or write starts shifting
// - counter decrements once per bit
// - shifting halts when counter reaches zero
// - bits move only when both ends ready
// - accesses wait while a sequence runs (status accesses are answered at once)
// - reset input and one ready status bit
// - partner stalls bounded near twelve microseconds
// - data port spans 1024 consecutive addresses
`timescale 1ns/1ps
`default_nettype none
`include "shifter_link_map.svh"

module serial_shifter_link #(
  parameter int CLK_PERIOD_NS = `SLK_CLK_PERIOD_NS,
  parameter int STALL_NS = `SLK_STALL_NS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire shifter_link_pkg::cpu_req_s cpu_req_i,
  output shifter_link_pkg::cpu_rsp_s cpu_rsp_o,
  input wire shifter_link_pkg::link_in_s link_i,
  output shifter_link_pkg::link_out_s link_o
);

  // ----------------------------------------------------------------------
  // derived constants and elaboration checks
  // ----------------------------------------------------------------------
  // stall bound follows the clock period
  localparam int STALL_CYC = STALL_NS / CLK_PERIOD_NS;
  localparam logic [`SLK_STALL_W-1:0] STALL_LAST = `SLK_STALL_W'(STALL_CYC - 1);

  // a clock slower than 16 MHz or a stall bound that does not fit is refused
  if (CLK_PERIOD_NS < 1 || CLK_PERIOD_NS > 62) begin : g_bad_clk
    $error("clock period outside 16 MHz and faster");
  end
  if (STALL_CYC < 2 || STALL_CYC > 4095) begin : g_bad_stall
    $error("stall bound does not fit the stall counter");
  end

  // ----------------------------------------------------------------------
  // partner pins through the synchroniser
  // ----------------------------------------------------------------------
  shifter_link_pkg::link_in_s lin_s;

  sync_two_ff #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({link_i.data, link_i.hs}),
    .sync_o({lin_s.data, lin_s.hs})
  );

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  shifter_link_pkg::core_s s_q;
  shifter_link_pkg::core_s s_d;

  logic [1:0] region;
  logic busy;
  logic access;
  logic bit_done;
  logic progress;
  logic [`SLK_CNT_W-1:0] cnt_dec;
  logic [`SLK_DATA_W-1:0] sh_out_next;
  logic [`SLK_DATA_W-1:0] sh_in_next;

  assign region = cpu_req_i.addr[`SLK_SEL_HI:`SLK_SEL_LO];
  assign busy = (s_q.st != shifter_link_pkg::ST_IDLE);
  // a fresh request that has not been answered yet
  assign access = cpu_req_i.sel && !s_q.served;
  assign cnt_dec = s_q.cnt - `SLK_CNT_W'(1);

  // shift values for send (zero fill) and receive (line bit fill)
  always_comb begin
    if (s_q.dir == `SLK_DIR_LEFT) begin
      sh_out_next = {s_q.shreg[`SLK_DATA_W-2:0], 1'b0};
      sh_in_next = {s_q.shreg[`SLK_DATA_W-2:0], lin_s.data};
    end else begin
      sh_out_next = {1'b0, s_q.shreg[`SLK_DATA_W-1:1]};
      sh_in_next = {lin_s.data, s_q.shreg[`SLK_DATA_W-1:1]};
    end
  end

  // ----------------------------------------------------------------------
  // next state: processor port, link sequencer, stall guard
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rsp.ack = 1'b0;
    bit_done = 1'b0;
    progress = 1'b0;
    if (!cpu_req_i.sel) begin
      s_d.served = 1'b0;
    end

    // data and control accesses wait while busy
    s_d.rsp.hold = access && busy && (region != `SLK_SEL_STAT);

    // processor accesses; status is answered even during a sequence
    if (access && (!busy || region == `SLK_SEL_STAT)) begin
      s_d.rsp.ack = 1'b1;
      s_d.rsp.hold = 1'b0;
      s_d.served = 1'b1;
      s_d.rsp.rdata = '0;
      case (region)
        // whole region aliases the data port
        `SLK_SEL_DATA: begin
          if (cpu_req_i.we) begin
            s_d.shreg = cpu_req_i.wdata;
            // store starts sending in the held direction
            s_d.st = shifter_link_pkg::ST_TX_PRESENT;
            s_d.lnk.data_oe = 1'b1;
            // first bit out is msb left, lsb right
            s_d.lnk.data = (s_q.dir == `SLK_DIR_LEFT) ? cpu_req_i.wdata[`SLK_DATA_W-1] : cpu_req_i.wdata[0];
          end else begin
            // reading returns the word and starts collecting
            s_d.rsp.rdata = s_q.shreg;
            s_d.st = shifter_link_pkg::ST_RX_WAIT;
          end
        end
        `SLK_SEL_CTRL: begin
          if (cpu_req_i.we) begin
            // count and direction from the control word
            s_d.cnt = cpu_req_i.wdata[`SLK_CTL_CNT_LSB +: `SLK_CNT_W];
            s_d.dir = cpu_req_i.wdata[`SLK_CTL_DIR_BIT];
            s_d.tmo = 1'b0;
            if (cpu_req_i.wdata[`SLK_CTL_CLR_BIT]) begin
              s_d.shreg = `SLK_RST_SHREG;
            end
          end else begin
            s_d.rsp.rdata[`SLK_CTL_CNT_LSB +: `SLK_CNT_W] = s_q.cnt;
            s_d.rsp.rdata[`SLK_CTL_DIR_BIT] = s_q.dir;
          end
        end
        `SLK_SEL_STAT: begin
          // single ready bit plus the stall flag
          s_d.rsp.rdata[`SLK_STA_READY_BIT] = !busy;
          s_d.rsp.rdata[`SLK_STA_TMO_BIT] = s_q.tmo;
        end
        default: begin
          s_d.rsp.rdata = '0; // unmapped region answers zero
        end
      endcase
    end

    // link handshake, four phases per bit
    case (s_q.st)
      shifter_link_pkg::ST_IDLE: begin
        s_d.lnk.hs = 1'b0;
      end
      shifter_link_pkg::ST_TX_PRESENT: begin
        // raise the strobe only once the partner has released
        if (!lin_s.hs) begin
          s_d.lnk.hs = 1'b1;
          s_d.st = shifter_link_pkg::ST_TX_ACK;
          progress = 1'b1;
        end
      end
      shifter_link_pkg::ST_TX_ACK: begin
        if (lin_s.hs) begin
          s_d.lnk.hs = 1'b0;
          bit_done = 1'b1;
          progress = 1'b1;
          s_d.shreg = sh_out_next;
          s_d.lnk.data = (s_q.dir == `SLK_DIR_LEFT) ? sh_out_next[`SLK_DATA_W-1] : sh_out_next[0];
          s_d.st = shifter_link_pkg::ST_TX_PRESENT;
        end
      end
      shifter_link_pkg::ST_RX_WAIT: begin
        if (lin_s.hs) begin
          s_d.shreg = sh_in_next;
          s_d.lnk.hs = 1'b1;
          s_d.st = shifter_link_pkg::ST_RX_ACK;
          progress = 1'b1;
        end
      end
      shifter_link_pkg::ST_RX_ACK: begin
        if (!lin_s.hs) begin
          s_d.lnk.hs = 1'b0;
          bit_done = 1'b1;
          progress = 1'b1;
          s_d.st = shifter_link_pkg::ST_RX_WAIT;
        end
      end
      default: begin
        s_d.st = shifter_link_pkg::ST_IDLE;
      end
    endcase

    if (bit_done) begin
      s_d.cnt = cnt_dec;
      // stop at zero; zero then means sixteen
      if (cnt_dec == '0) begin
        s_d.st = shifter_link_pkg::ST_IDLE;
        s_d.lnk.data_oe = 1'b0;
      end
    end

    // a partner that stalls too long aborts the sequence
    if (!busy || progress) begin
      s_d.stall = '0;
    end else if (s_q.stall == STALL_LAST) begin
      s_d.stall = '0;
      s_d.st = shifter_link_pkg::ST_IDLE;
      s_d.lnk.hs = 1'b0;
      s_d.lnk.data_oe = 1'b0;
      s_d.cnt = `SLK_RST_CNT;
      s_d.tmo = 1'b1; // set wins; clearing happens only when idle
    end else begin
      s_d.stall = s_q.stall + `SLK_STALL_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // synchronous reset to idle, count zero, left mode
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_rsp_o = s_q.rsp;
  assign link_o = s_q.lnk;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // data line driven only while sending
  drive_when_send_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    link_o.data_oe |-> (s_q.st == shifter_link_pkg::ST_TX_PRESENT || s_q.st == shifter_link_pkg::ST_TX_ACK)
  ) else $error("data line driven outside a send");

  // a held access is never acknowledged in the same cycle
  hold_no_ack_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cpu_rsp_o.hold |-> !cpu_rsp_o.ack && $past(busy)
  ) else $error("access acknowledged while shifting");

  // counter moves down by exactly one per bit
  count_step_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    bit_done |=> s_q.cnt == $past(cnt_dec)
  ) else $error("counter did not step by one");

  // shifting stops once the count reaches zero
  halt_at_zero_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (bit_done && cnt_dec == '0) |=> (s_q.st == shifter_link_pkg::ST_IDLE) && !link_o.hs
  ) else $error("shifting went on past zero");

  // a data store starts the send and drives the line next cycle
  store_starts_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (access && !busy && region == `SLK_SEL_DATA && cpu_req_i.we)
      |=> s_q.st == shifter_link_pkg::ST_TX_PRESENT && link_o.data_oe && cpu_rsp_o.ack
  ) else $error("data store did not start sending");

  // a data read starts collection
  read_starts_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (access && !busy && region == `SLK_SEL_DATA && !cpu_req_i.we)
      |=> s_q.st == shifter_link_pkg::ST_RX_WAIT && !link_o.data_oe
  ) else $error("data read did not start collecting");

  // strobe rises only after partner released its line
  strobe_rise_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ($rose(link_o.hs) && s_q.st == shifter_link_pkg::ST_TX_ACK) |-> !$past(lin_s.hs)
  ) else $error("strobe raised while partner still high");

  // left mode presents the top bit of the stored word
  msb_first_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == shifter_link_pkg::ST_TX_PRESENT && s_q.dir == `SLK_DIR_LEFT)
      |-> link_o.data == s_q.shreg[`SLK_DATA_W-1]
  ) else $error("left mode did not present msb");

  // stall counter never passes its bound
  stall_bound_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_q.stall <= STALL_LAST
  ) else $error("stall counter beyond bound");

  // status read reports ready exactly when idle
  ready_bit_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (access && region == `SLK_SEL_STAT && !cpu_req_i.we)
      |=> cpu_rsp_o.rdata[`SLK_STA_READY_BIT] == !$past(busy)
  ) else $error("ready bit wrong");

  // right mode presents the bottom bit of the stored word
  lsb_first_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == shifter_link_pkg::ST_TX_PRESENT && s_q.dir == `SLK_DIR_RIGHT)
      |-> link_o.data == s_q.shreg[0]
  ) else $error("right mode did not present lsb");

  // acknowledge goes up only after the partner strobe was seen
  rx_ack_rise_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ($rose(link_o.hs) && s_q.st == shifter_link_pkg::ST_RX_ACK)
      |-> $past(lin_s.hs)
  ) else $error("acknowledge raised without a strobe");

  // a partner idle for the whole bound ends the sequence
  stall_abort_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (busy && !progress && s_q.stall == STALL_LAST)
      |=> s_q.st == shifter_link_pkg::ST_IDLE && s_q.tmo && !link_o.data_oe && !link_o.hs
  ) else $error("stalled sequence not aborted");

  // a control write loads count and direction together
  ctrl_load_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (access && !busy && region == `SLK_SEL_CTRL && cpu_req_i.we)
      |=> s_q.cnt == $past(cpu_req_i.wdata[`SLK_CTL_CNT_LSB +: `SLK_CNT_W])
        && s_q.dir == $past(cpu_req_i.wdata[`SLK_CTL_DIR_BIT])
  ) else $error("control word not loaded");

endmodule : serial_shifter_link

`default_nettype wire

// ==== hdl/shifter_link_map.svh ====
// register map, field positions, reset values and timing counts of the serial shifter link
// assumes a word-addressed processor port and a 100 MHz control clock
`ifndef SHIFTER_LINK_MAP_SVH
`define SHIFTER_LINK_MAP_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define SLK_DATA_W 16
`define SLK_CNT_W 4
`define SLK_ADDR_W 12
`define SLK_STALL_W 12

// ----------------------------------------------------------------------
// address decode: addr[11:10] picks the region, the rest is don't-care
// ----------------------------------------------------------------------
`define SLK_SEL_HI 11
`define SLK_SEL_LO 10
`define SLK_SEL_DATA 2'h0
`define SLK_SEL_CTRL 2'h1
`define SLK_SEL_STAT 2'h2
`define SLK_DATA_SPAN 1024

// ----------------------------------------------------------------------
// control word fields (shift_count_and_direction)
// ----------------------------------------------------------------------
`define SLK_CTL_CNT_LSB 0
`define SLK_CTL_DIR_BIT 4
`define SLK_CTL_CLR_BIT 5
`define SLK_DIR_LEFT 1'b0
`define SLK_DIR_RIGHT 1'b1

// ----------------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------------
`define SLK_STA_READY_BIT 0
`define SLK_STA_TMO_BIT 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SLK_RST_SHREG 16'h0000
`define SLK_RST_CNT 4'h0
`define SLK_RST_DIR 1'b0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SLK_CLK_PERIOD_NS 10
`define SLK_STALL_NS 12000
`define SLK_STALL_CYC ((`SLK_STALL_NS) / (`SLK_CLK_PERIOD_NS))

`endif

// ==== hdl/shifter_link_pkg.sv ====
// types shared by the serial shifter link: bus carriers, link carriers, state
// assumes shifter_link_map.svh is on the include path
`include "shifter_link_map.svh"

package shifter_link_pkg;

  // ----------------------------------------------------------------------
  // link sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TX_PRESENT,
    ST_TX_ACK,
    ST_RX_WAIT,
    ST_RX_ACK
  } link_state_e;

  // processor request, held until acknowledged
  typedef struct packed {
    logic sel;
    logic we;
    logic [`SLK_ADDR_W-1:0] addr;
    logic [`SLK_DATA_W-1:0] wdata;
  } cpu_req_s;

  // processor answer
  typedef struct packed {
    logic ack;
    logic hold;
    logic [`SLK_DATA_W-1:0] rdata;
  } cpu_rsp_s;

  // pins driven toward the partner
  typedef struct packed {
    logic data;
    logic data_oe;
    logic hs;
  } link_out_s;

  // pins sampled from the partner
  typedef struct packed {
    logic data;
    logic hs;
  } link_in_s;

  // whole state of the shifter
  typedef struct packed {
    link_state_e st;
    logic [`SLK_DATA_W-1:0] shreg;
    logic [`SLK_CNT_W-1:0] cnt;
    logic dir;
    logic tmo;
    logic served;
    logic [`SLK_STALL_W-1:0] stall;
    cpu_rsp_s rsp;
    link_out_s lnk;
  } core_s;

endpackage : shifter_link_pkg

// ==== hdl/sync_two_ff.sv ====
// two flip-flop synchroniser for pins that arrive from the partner
// assumes the inputs are asynchronous levels; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : sync_two_ff

`default_nettype wire

// ==== tb/interprocessor_serial_shifter_link_test.sv ====
// self-checking bench for the serial shifter link with a partner shifter model
// assumes a 100 MHz clock and a shortened stall limit of 20 cycles
`timescale 1ns/1ps
`default_nettype none

module interprocessor_serial_shifter_link_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  shifter_link_pkg::cpu_req_s cpu_req = '0;
  shifter_link_pkg::cpu_rsp_s cpu_rsp;
  shifter_link_pkg::link_in_s link_in;
  shifter_link_pkg::link_out_s link_out;
  logic tx_go = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic [4:0] tx_bits = 5'h00;
  logic [3:0] lag = 4'h0;
  logic [15:0] rx_word;
  int miscompares = 0;
  int total_checks = 0;

  always #5 clk_i = ~clk_i;

  serial_shifter_link #(.CLK_PERIOD_NS(10), .STALL_NS(200)) i_dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cpu_req_i(cpu_req),
    .cpu_rsp_o(cpu_rsp),
    .link_i(link_in),
    .link_o(link_out)
  );

  link_partner i_partner (
    .clk_i(clk_i),
    .near_i(link_out),
    .pin_o(link_in),
    .tx_go_i(tx_go),
    .tx_word_i(tx_word),
    .tx_bits_i(tx_bits),
    .lag_i(lag),
    .rx_word_o(rx_word)
  );

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one processor access; sel stands until ack is sampled, then drops for a cycle
  task automatic access(input logic we, input logic [11:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic held);
    held = 1'b0;
    @(posedge clk_i);
    cpu_req <= '{sel: 1'b1, we: we, addr: addr, wdata: wdata};
    for (int n = 0; n < 400; n++) begin
      @(posedge clk_i);
      if (cpu_rsp.hold === 1'b1) held = 1'b1;
      if (cpu_rsp.ack === 1'b1) break;
    end
    // an access that never finishes counts against the run
    if (cpu_rsp.ack !== 1'b1) begin
      miscompares++;
      $display("unexpected ack: expected 1 seen %b", cpu_rsp.ack);
    end
    rdata = cpu_rsp.rdata;
    cpu_req.sel <= 1'b0;
  endtask : access

  task automatic wr(input logic [11:0] addr, input logic [15:0] wdata);
    logic [15:0] d;
    logic h;
    access(1'b1, addr, wdata, d, h);
  endtask : wr

  task automatic rd_chk(input string what, input logic [11:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic h;
    access(1'b0, addr, 16'h0000, d, h);
    check(what, exp, d);
  endtask : rd_chk

  // polls the status word, which answers even while shifting
  task automatic wait_ready();
    logic [15:0] d;
    logic h;
    d = 16'h0000;
    for (int n = 0; n < 300 && d[0] !== 1'b1; n++) begin
      access(1'b0, 12'h800, 16'h0000, d, h);
    end
    if (d[0] !== 1'b1) begin
      miscompares++;
      $display("unexpected ready: expected 1 seen %b", d[0]);
    end
  endtask : wait_ready

  task automatic partner_send(input logic [15:0] word, input logic [4:0] bits);
    @(posedge clk_i);
    tx_word <= word;
    tx_bits <= bits;
    tx_go <= 1'b1;
    @(posedge clk_i);
    tx_go <= 1'b0;
  endtask : partner_send

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd_chk("control after reset", 12'h400, 16'h0000);
    rd_chk("status after reset", 12'h800, 16'h0001);
  endtask : t_reset

  // short left send, then a three-bit zero pad; exact bit counts show in rx_word
  task automatic t_send_left();
    wr(12'h400, 16'h0004);
    rd_chk("control readback", 12'h400, 16'h0004);
    wr(12'h000, 16'hA000);
    wait_ready();
    check("left bits on link", 16'h000A, rx_word & 16'h000F);
    rd_chk("count back to zero", 12'h400, 16'h0000);
    wr(12'h400, 16'h0003);
    wr(12'h001, 16'h0000);
    wait_ready();
    check("pad bits on link", 16'h0050, rx_word & 16'h00FF);
  endtask : t_send_left

  // full right send at the top alias, slow partner, access held meanwhile
  task automatic t_send_right();
    logic [15:0] d;
    logic h;
    lag <= 4'h3;
    wr(12'h400, 16'h0010);
    wr(12'h3FF, 16'h1234);
    access(1'b1, 12'h400, 16'h0010, d, h);
    check("held while shifting", 16'h0001, {15'h0000, h});
    check("right bits on link", 16'h2C48, rx_word);
    lag <= 4'h0;
  endtask : t_send_right

  // left receives of eight and sixteen bits, a right receive of four, then a read never fed
  task automatic t_receive();
    wr(12'h400, 16'h0028);
    rd_chk("cleared word", 12'h005, 16'h0000);
    partner_send(16'hA500, 5'h08);
    wait_ready();
    rd_chk("received word", 12'h006, 16'h00A5);
    partner_send(16'h1234, 5'h10);
    wait_ready();
    wr(12'h400, 16'h0014);
    rd_chk("full count word", 12'h007, 16'h1234);
    partner_send(16'hC000, 5'h04);
    wait_ready();
    rd_chk("right received word", 12'h008, 16'h3123);
    wait_ready();
    rd_chk("timeout status", 12'h800, 16'h0003);
    wr(12'h400, 16'h0020);
    rd_chk("timeout cleared", 12'h800, 16'h0001);
  endtask : t_receive

  task automatic t_unmapped();
    wr(12'hC00, 16'hFFFF);
    rd_chk("unmapped read", 12'hC00, 16'h0000);
    wr(12'h800, 16'h0002);
    rd_chk("status write ignored", 12'h800, 16'h0001);
    rd_chk("control untouched", 12'h400, 16'h0000);
  endtask : t_unmapped

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // main sequence after a two-cycle reset
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_send_left();
    t_send_right();
    t_receive();
    t_unmapped();
    final_report();
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
endmodule : interprocessor_serial_shifter_link_test
`default_nettype wire

// ==== tb/link_partner.sv ====
// behavioural matching shifter standing on the far end of the serial link
// assumes the block under test shares one data wire and swaps handshakes with it
`timescale 1ns/1ps
`default_nettype none

module link_partner (
  input wire logic clk_i,
  input wire shifter_link_pkg::link_out_s near_i,
  output shifter_link_pkg::link_in_s pin_o,
  input wire logic tx_go_i,
  input wire logic [15:0] tx_word_i,
  input wire logic [4:0] tx_bits_i,
  input wire logic [3:0] lag_i,
  output logic [15:0] rx_word_o
);
  logic hs_q = 1'b0;
  logic drv_q = 1'b0;
  logic dat_q = 1'b0;
  logic last_q = 1'b0;

  // ----------------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------------
  // one shared data line
  // a released wire shows the inverse of its last level, so a stale bit never passes
  assign pin_o = '{data: (near_i.data_oe ? near_i.data : (drv_q ? dat_q : ~last_q)), hs: hs_q};

  // last level seen on the wire
  always @(posedge clk_i) last_q <= pin_o.data;

  // ----------------------------------------------------------------------
  // bit sequencing
  // ----------------------------------------------------------------------
  // moves just after an edge, once the near end's registers have settled
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic take_bit();
    repeat (lag_i) step();
    rx_word_o = {rx_word_o[14:0], pin_o.data};
    hs_q = 1'b1;
    while (near_i.hs) step();
    hs_q = 1'b0;
  endtask : take_bit

  task automatic send_word();
    for (int i = 0; i < tx_bits_i; i++) begin
      drv_q = 1'b1;
      dat_q = tx_word_i[15 - i];
      step();
      while (near_i.hs) step();
      hs_q = 1'b1;
      while (!near_i.hs) step();
      repeat (lag_i) step();
      hs_q = 1'b0;
      dat_q = ~dat_q; // hold time over, the bit goes stale on purpose
    end
    drv_q = 1'b0;
  endtask : send_word

  initial begin
    rx_word_o = 16'h0000;
    forever begin
      step();
      if (tx_go_i) begin
        send_word();
      end else if (near_i.data_oe && near_i.hs) begin
        take_bit();
      end
    end
  end
endmodule : link_partner
`default_nettype wire
